// ==== logic/gpdc_consts.vh ====
/*
  Constants of the gripper process data command interpreter: command
  and status bit positions, travel profile codes, error codes, reset
  values and timing. Assumes inclusion by bare name from logic files.
*/
`ifndef GPDC_CONSTS_VH
`define GPDC_CONSTS_VH

// ----------------------------------------------------------------
// Command word bits
// ----------------------------------------------------------------
`define GPDC_CMD_XFER 16'h0001
`define GPDC_CMD_STORE 16'h0002
`define GPDC_CMD_DIRCLR 16'h0004
`define GPDC_CMD_TEACH 16'h0008
`define GPDC_CMD_CALIB 16'h0080
`define GPDC_CMD_OUTER 16'h0100
`define GPDC_CMD_INNER 16'h0200
`define GPDC_CMD_FACK 16'h8000
`define GPDC_CMD_NONE 16'h0000

// ----------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------
`define GPDC_ST_BOOT 6
`define GPDC_ST_OUTER 8
`define GPDC_ST_TAUGHT 9
`define GPDC_ST_INNER 10
`define GPDC_ST_BETWEEN 11
`define GPDC_ST_ACK 12
`define GPDC_ST_DIR_OUT 13
`define GPDC_ST_DIR_IN 14
`define GPDC_ST_ERROR 15

// ----------------------------------------------------------------
// Travel profile codes
// ----------------------------------------------------------------
`define GPDC_PRF_OUTSIDE 8'h3C
`define GPDC_PRF_OUTSIDE_H 8'h3F
`define GPDC_PRF_INSIDE 8'h46
`define GPDC_PRF_INSIDE_H 8'h49
`define GPDC_PRF_UNIV 8'h64
`define GPDC_PRF_UNIV_H 8'h67

// ----------------------------------------------------------------
// Error codes, reset values, limits
// ----------------------------------------------------------------
`define GPDC_ERR_NONE 16'h0000
`define GPDC_ERR_PROFILE 16'h0001
`define GPDC_ERR_FORCE 16'h0002
`define GPDC_ERR_LOST 16'h0003
`define GPDC_RST_PROFILE 8'h64
`define GPDC_RST_FORCE 8'h01
`define GPDC_RST_WORD 16'h0000
`define GPDC_FORCE_MIN 8'h01
`define GPDC_FORCE_MAX 8'h04
`define GPDC_OUTER_POS 16'h0000
`define GPDC_INNER_POS 16'h07D0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define GPDC_CLK_KHZ 100000
`define GPDC_HOLD_MS 500
`define GPDC_BOOT_CYCLES 16
`endif

// ==== logic/gpdc_recipe_mem.v ====
/*
  Recipe store: one taught position per recipe index.
  Assumes a single clock; read data come out of a register one
  cycle after the address.
*/
`timescale 1ns/10ps
module gpdc_recipe_mem #(
  parameter AW = 6, // Address width
  parameter DW = 16 // Data width
) (
  input wire clk, // System clock
  input wire wr_en, // Write strobe
  input wire [AW-1:0] wr_addr, // Write address
  input wire [DW-1:0] wr_data, // Write data
  input wire [AW-1:0] rd_addr, // Read address
  output reg [DW-1:0] rd_data // Registered read data
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Write port and registered read port
  always @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// ==== logic/gpdc_hold_timer.v ====
/*
  Follow-up current timer: holds busy for a fixed count after start.
  Assumes clk and active low asynchronous rst_b of the caller.
*/
`timescale 1ns/10ps
module gpdc_hold_timer #(
  parameter CW = 26, // Counter width
  parameter [CW-1:0] CYCLES = 26'd50000000 // Hold length in cycles
) (
  input wire clk, // System clock
  input wire rst_b, // Asynchronous reset, active low
  input wire start, // Start pulse
  input wire cancel, // Cancel pulse
  output wire busy // High while holding
);

  reg [CW-1:0] cnt_reg;
  reg [CW-1:0] cnt_next;

  // ----------------------------------------------------------------
  // Down counter
  // ----------------------------------------------------------------
  // Load on start, stop on cancel, else count down to zero
  always @*
  begin
    cnt_next = cnt_reg;
    if (cancel)
      cnt_next = {CW{1'b0}};
    else if (start)
      cnt_next = CYCLES;
    else if (cnt_reg != {CW{1'b0}})
      cnt_next = cnt_reg - {{(CW-1){1'b0}}, 1'b1};
  end

  // Counter register
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_reg <= {CW{1'b0}};
    else
      cnt_reg <= cnt_next;
  end

  assign busy = (cnt_reg != {CW{1'b0}});

endmodule

// ==== logic/gpdc_top.v ====
/*
  Gripper process data command interpreter: decodes the cyclic command
  word, runs the transfer handshake, keeps recipes, drives motion
  requests and builds the status and diagnosis words.
  Assumes process data, jaw position and motion events come from logic
  on the same clock.
*/
// Behaviour
// - Teach stores jaw position into selected recipe, only for nonzero index.
// - Calibrate bit alone starts readjustment of both end positions.
// - Go-outer bit starts motion toward outer end position.
// - Go-inner bit starts motion toward inner end position.
// - Fault acknowledge clears resettable errors, keeps non-resettable ones.
// - Outside gripping: inward at chosen force, outward fast.
// - Inside gripping: outward at chosen force, inward fast.
// - Universal: both directions at force-derived speed.
// - Follow-up profiles hold current 500 ms after motion, per direction.
// - Reduced variant accepts only the three base profiles.
// - Workpiece loss drives jaws on to end position and reports.
// - Nonzero recipe index below 1 << AW on handshake loads that stored recipe.
// - Taught flag set while jaw lies within window around taught spot.
// - Force level accepts codes 1 to 4, sets speed and current.
// - Window is symmetric, 0.01 mm units, each side of taught spot.
// - Boot-complete flag rises once booting has finished.
// - Outer and inner flags show jaws at the end positions.
// - Between flag set when outer, inner and taught flags are clear.
// - Acknowledge flag set once data taken after command value one.
// - Command zero after acknowledge clears the acknowledge flag.
// - Direction flags show whether last motion went outer or inner.
// - Top status bit marks active error; code shown in diagnosis.
`timescale 1ns/10ps
`include "gpdc_consts.vh"
module gpdc_top #(
  parameter REDUCED = 0, // 1 for the reduced variant
  parameter AW = 6, // Recipe address width
  parameter HOLD_CYCLES = `GPDC_HOLD_MS * `GPDC_CLK_KHZ, // Hold time
  parameter [15:0] OUTER_POS = `GPDC_OUTER_POS, // Outer end position
  parameter [15:0] INNER_POS = `GPDC_INNER_POS // Inner end position
) (
  input wire clk, // System clock
  input wire rst_b, // Asynchronous reset, active low
  input wire [15:0] command_word, // Command word
  input wire [7:0] travel_profile_select, // Travel profile
  input wire [7:0] recipe_index, // Recipe index
  input wire [15:0] taught_position, // Taught position, 0.01 mm
  input wire [7:0] force_level, // Force level 1..4
  input wire [7:0] position_window, // Window, 0.01 mm
  input wire [15:0] jaw_position, // Measured jaw position
  input wire motion_done, // Motion finished pulse
  input wire workpiece_lost, // Gripped part lost pulse
  input wire hard_fault, // Non-resettable fault level
  input wire [15:0] hard_fault_code, // Code of hard fault
  output reg [15:0] gripper_status, // Status word
  output reg [15:0] diagnosis, // Error code word
  output reg move_start, // Motion request pulse
  output reg move_inward, // Direction of request
  output reg move_fast, // High speed travel
  output reg [2:0] move_force, // Force level of request
  output reg move_abort, // Cancel current motion pulse
  output reg calib_start, // Readjustment pulse
  output wire hold_current // Follow-up current active
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_LOAD = 2'b01;
  localparam ST_ACK = 2'b10;
  localparam [7:0] FORCE_RST = `GPDC_RST_FORCE; // Reset force level

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [15:0] cmd_prev_reg;
  reg ack_reg;
  reg [7:0] profile_reg;
  reg [2:0] force_reg;
  reg [7:0] window_reg;
  reg [15:0] taught_reg;
  reg dir_out_reg;
  reg dir_in_reg;
  reg [15:0] err_reg;
  reg [4:0] boot_cnt_reg;
  reg boot_reg;
  reg [15:0] mem_wdata;
  reg mem_we;
  reg take_pd;
  reg take_mem;
  reg prf_ok;
  reg hold_start;
  wire [15:0] mem_rdata;
  wire [4:0] cmd_ones;
  wire cmd_legal;
  wire cmd_new;
  wire idx_ok;
  wire force_ok;
  wire outside_p;
  wire inside_p;
  wire hold_in;
  wire hold_out;
  wire [16:0] win_lo;
  wire [16:0] win_hi;
  wire at_outer;
  wire at_inner;
  wire at_taught;
  wire err_any;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Count set bits of the command word
  genvar gi;
  wire [4:0] ones_acc [0:16];
  assign ones_acc[0] = 5'h00;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_ones
      assign ones_acc[gi+1] = ones_acc[gi] + {4'h0, command_word[gi]};
    end
  endgenerate
  assign cmd_ones = ones_acc[16];

  // Only zero or one bit set counts as a command
  assign cmd_legal = (cmd_ones <= 5'h01);
  assign cmd_new = cmd_legal && (command_word != cmd_prev_reg) &&
                   (command_word != `GPDC_CMD_NONE);
  assign idx_ok = (recipe_index != 8'h00) &&
                  (recipe_index < (9'h001 << AW));

  // ----------------------------------------------------------------
  // Profile and force checks
  // ----------------------------------------------------------------
  // Permitted profile codes, reduced variant only the base three
  always @*
  begin
    case (travel_profile_select)
      `GPDC_PRF_OUTSIDE, `GPDC_PRF_INSIDE, `GPDC_PRF_UNIV:
        prf_ok = 1'b1;
      `GPDC_PRF_OUTSIDE_H, `GPDC_PRF_INSIDE_H, `GPDC_PRF_UNIV_H:
        prf_ok = (REDUCED == 0);
      default:
        prf_ok = 1'b0;
    endcase
  end

  assign force_ok = (force_level >= `GPDC_FORCE_MIN) &&
                    (force_level <= `GPDC_FORCE_MAX);

  // Profile families of the active profile
  assign outside_p = (profile_reg == `GPDC_PRF_OUTSIDE) ||
                     (profile_reg == `GPDC_PRF_OUTSIDE_H);
  assign inside_p = (profile_reg == `GPDC_PRF_INSIDE) ||
                    (profile_reg == `GPDC_PRF_INSIDE_H);
  // Follow-up current per direction
  assign hold_in = (profile_reg == `GPDC_PRF_OUTSIDE_H) ||
                   (profile_reg == `GPDC_PRF_UNIV_H);
  assign hold_out = (profile_reg == `GPDC_PRF_INSIDE_H) ||
                    (profile_reg == `GPDC_PRF_UNIV_H);

  // ----------------------------------------------------------------
  // Handshake state machine
  // ----------------------------------------------------------------
  // Take data on command one, release on command zero
  always @*
  begin
    state_next = state_reg;
    take_pd = 1'b0;
    take_mem = 1'b0;
    case (state_reg)
      ST_IDLE:
        if (command_word == `GPDC_CMD_XFER)
        begin
          take_pd = 1'b1;
          if (idx_ok)
            state_next = ST_LOAD;
          else
            state_next = ST_ACK;
        end
      ST_LOAD:
      begin
        take_mem = 1'b1;
        state_next = ST_ACK;
      end
      ST_ACK:
        if (command_word == `GPDC_CMD_NONE)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // State, acknowledge flag and command history
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= ST_IDLE;
      ack_reg <= 1'b0;
      cmd_prev_reg <= `GPDC_RST_WORD;
    end
    else
    begin
      state_reg <= state_next;
      ack_reg <= (state_next == ST_ACK);
      cmd_prev_reg <= command_word;
    end
  end

  // ----------------------------------------------------------------
  // Active data set
  // ----------------------------------------------------------------
  // Latch process data, taught spot from recipe when index nonzero and below 1 << AW
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      profile_reg <= `GPDC_RST_PROFILE;
      force_reg <= FORCE_RST[2:0];
      window_reg <= 8'h00;
      taught_reg <= `GPDC_RST_WORD;
    end
    else
    begin
      if (take_pd)
      begin
        if (prf_ok)
          profile_reg <= travel_profile_select;
        if (force_ok)
          force_reg <= force_level[2:0];
        window_reg <= position_window;
        taught_reg <= taught_position;
      end
      if (take_mem)
        taught_reg <= mem_rdata;
      if (mem_we && (command_word == `GPDC_CMD_TEACH))
        taught_reg <= jaw_position;
    end
  end

  // ----------------------------------------------------------------
  // Recipe store
  // ----------------------------------------------------------------
  // Teach stores jaw position, store command the process value
  always @*
  begin
    mem_we = 1'b0;
    mem_wdata = taught_position;
    if (cmd_new && idx_ok && (state_reg == ST_IDLE))
    begin
      if (command_word == `GPDC_CMD_TEACH)
      begin
        mem_we = 1'b1;
        mem_wdata = jaw_position;
      end
      else if (command_word == `GPDC_CMD_STORE)
        mem_we = 1'b1;
    end
  end

  gpdc_recipe_mem #(
    .AW(AW),
    .DW(16)
  ) u_mem (
    .clk(clk),
    .wr_en(mem_we),
    .wr_addr(recipe_index[AW-1:0]),
    .wr_data(mem_wdata),
    .rd_addr(recipe_index[AW-1:0]),
    .rd_data(mem_rdata)
  );

  // ----------------------------------------------------------------
  // Motion requests and direction flags
  // ----------------------------------------------------------------
  // Start, abort, calibrate pulses and direction memory
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      move_start <= 1'b0;
      move_inward <= 1'b0;
      move_fast <= 1'b0;
      move_force <= FORCE_RST[2:0];
      move_abort <= 1'b0;
      calib_start <= 1'b0;
      dir_out_reg <= 1'b0;
      dir_in_reg <= 1'b0;
      hold_start <= 1'b0;
    end
    else
    begin
      move_start <= 1'b0;
      move_abort <= take_pd; // New handshake cancels motion
      calib_start <= 1'b0;
      hold_start <= motion_done &&
                    (move_inward ? hold_in : hold_out);
      if (cmd_new && (state_reg == ST_IDLE))
      begin
        if ((command_word == `GPDC_CMD_OUTER) && !dir_out_reg)
        begin
          move_start <= 1'b1;
          move_inward <= 1'b0;
          move_force <= force_reg;
          move_fast <= outside_p;
          dir_out_reg <= 1'b1;
          dir_in_reg <= 1'b0;
        end
        if ((command_word == `GPDC_CMD_INNER) && !dir_in_reg)
        begin
          move_start <= 1'b1;
          move_inward <= 1'b1;
          move_force <= force_reg;
          move_fast <= inside_p;
          dir_in_reg <= 1'b1;
          dir_out_reg <= 1'b0;
        end
        if (command_word == `GPDC_CMD_CALIB)
          calib_start <= 1'b1;
        if (command_word == `GPDC_CMD_DIRCLR)
        begin
          dir_out_reg <= 1'b0;
          dir_in_reg <= 1'b0;
        end
      end
      if (workpiece_lost)
      begin
        move_start <= 1'b1;
        move_fast <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Follow-up current
  // ----------------------------------------------------------------
  gpdc_hold_timer #(
    .CW(26),
    .CYCLES(HOLD_CYCLES[25:0])
  ) u_hold (
    .clk(clk),
    .rst_b(rst_b),
    .start(hold_start),
    .cancel(move_start || move_abort),
    .busy(hold_current)
  );

  // ----------------------------------------------------------------
  // Errors
  // ----------------------------------------------------------------
  // Resettable error code; new event wins over acknowledge
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      err_reg <= `GPDC_ERR_NONE;
    else if (workpiece_lost)
      err_reg <= `GPDC_ERR_LOST;
    else if (take_pd && !prf_ok)
      err_reg <= `GPDC_ERR_PROFILE;
    else if (take_pd && !force_ok)
      err_reg <= `GPDC_ERR_FORCE;
    else if (cmd_new && (command_word == `GPDC_CMD_FACK))
      err_reg <= `GPDC_ERR_NONE;
  end

  // Hard fault is never cleared by acknowledge
  assign err_any = hard_fault || (err_reg != `GPDC_ERR_NONE);

  // ----------------------------------------------------------------
  // Boot
  // ----------------------------------------------------------------
  // Boot-complete flag after a short start-up count
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      boot_cnt_reg <= 5'h00;
      boot_reg <= 1'b0;
    end
    else if (!boot_reg)
    begin
      boot_cnt_reg <= boot_cnt_reg + 5'h01;
      if (boot_cnt_reg == (`GPDC_BOOT_CYCLES - 1))
        boot_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Position compare
  // ----------------------------------------------------------------
  // Symmetric window, widened by one bit against wrap
  assign win_lo = {1'b0, taught_reg} - {9'h000, window_reg};
  assign win_hi = {1'b0, taught_reg} + {9'h000, window_reg};
  assign at_taught = (win_lo[16] || ({1'b0, jaw_position} >= win_lo)) &&
                     ({1'b0, jaw_position} <= win_hi);
  assign at_outer = (jaw_position <= OUTER_POS);
  assign at_inner = (jaw_position >= INNER_POS);

  // ----------------------------------------------------------------
  // Status and diagnosis words
  // ----------------------------------------------------------------
  // Registered status and diagnosis outputs
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gripper_status <= `GPDC_RST_WORD;
      diagnosis <= `GPDC_RST_WORD;
    end
    else
    begin
      gripper_status <= `GPDC_RST_WORD;
      gripper_status[`GPDC_ST_BOOT] <= boot_reg;
      gripper_status[`GPDC_ST_OUTER] <= at_outer;
      gripper_status[`GPDC_ST_TAUGHT] <= at_taught;
      gripper_status[`GPDC_ST_INNER] <= at_inner;
      gripper_status[`GPDC_ST_BETWEEN] <=
        !(at_outer || at_inner || at_taught);
      gripper_status[`GPDC_ST_ACK] <= ack_reg;
      gripper_status[`GPDC_ST_DIR_OUT] <= dir_out_reg;
      gripper_status[`GPDC_ST_DIR_IN] <= dir_in_reg;
      gripper_status[`GPDC_ST_ERROR] <= err_any;
      diagnosis <= hard_fault ? hard_fault_code : err_reg;
    end
  end

endmodule

// ==== testbench/gpdc_top_chk.sv ====
/*
  Checker of the gripper command interpreter: boot, handshake,
  position, direction, error and hold relations at the top ports.
  Assumes it is bound onto gpdc_top.
*/
`timescale 1ns/10ps
module gpdc_top_chk (
  input wire clk, // Clock
  input wire rst_b, // Reset, active low
  input wire [15:0] command_word, // Command
  input wire motion_done, // Travel end
  input wire workpiece_lost, // Part lost
  input wire [15:0] gripper_status, // Status
  input wire [15:0] diagnosis, // Error code
  input wire move_start, // Move pulse
  input wire move_inward, // Direction
  input wire calib_start, // Calib pulse
  input wire hold_current // Hold active
);
  reg [4:0] bc_reg; // Edges since release
  wire [15:0] st = gripper_status;
  // Count edges after reset, saturating
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      bc_reg <= 5'h00;
    else if (bc_reg != 5'h1F)
      bc_reg <= bc_reg + 5'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----
  // Motion requests not caused by part loss
  // ----
  sequence s_out_req;
    move_start && !move_inward && !$past(workpiece_lost);
  endsequence
  sequence s_in_req;
    move_start && move_inward && !$past(workpiece_lost);
  endsequence
  a_boot_late: assert property (bc_reg > 5'h14 |-> st[6])
    else $error("boot flag missing");
  a_between_flag: assert property (st[6] |->
    st[11] == !(st[8] || st[9] || st[10])) else $error("between flag");
  a_ack_rise: assert property ($rose(st[12]) |->
    $past(command_word, 2) == 16'h0001) else $error("ack without 1");
  a_ack_hold: assert property (st[12] && command_word != 16'h0000
    |=> st[12]) else $error("ack dropped early");
  a_ack_fall: assert property ($fell(st[12]) |->
    $past(command_word, 2) == 16'h0000) else $error("ack fell early");
  a_out_dir: assert property (s_out_req |=> st[13])
    else $error("outer flag wrong");
  a_in_dir: assert property (s_in_req |=> st[14])
    else $error("inner flag wrong");
  a_dir_excl: assert property (!(st[13] && st[14]))
    else $error("both direction flags");
  a_multi_ignored: assert property ($countones(command_word) > 1
    && !workpiece_lost |=> !move_start && !calib_start)
    else $error("multi bit acted");
  a_calib_cause: assert property (calib_start |->
    $past(command_word) == 16'h0080) else $error("calib cause");
  a_error_bit: assert property (st[6] |->
    st[15] == (diagnosis != 16'h0000)) else $error("error bit");
  a_hold_cause: assert property ($rose(hold_current) |->
    $past(motion_done, 2)) else $error("hold cause");
endmodule
bind gpdc_top gpdc_top_chk chk (.clk(clk), .rst_b(rst_b),
  .command_word(command_word), .motion_done(motion_done),
  .workpiece_lost(workpiece_lost), .gripper_status(gripper_status),
  .diagnosis(diagnosis), .move_start(move_start),
  .move_inward(move_inward), .calib_start(calib_start),
  .hold_current(hold_current));

// ==== testbench/gpdc_jaw_model.sv ====
/*
  Jaw mechanics stand-in: a request puts the jaws midway at once and
  at the end position four edges later. Assumes the design's clock.
*/
`timescale 1ns/10ps
module gpdc_jaw_model (
  input wire clk, // Clock
  input wire rst_b, // Reset, active low
  input wire move_start, // Move request
  input wire move_inward, // Direction
  output reg [15:0] jaw_position, // Position
  output reg motion_done // End pulse
);
  reg [2:0] cnt_reg; // Travel edges left
  // Travel and end pulse
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      jaw_position <= 16'h0000;
      motion_done <= 1'b0;
      cnt_reg <= 3'h0;
    end
    else
    begin
      motion_done <= (cnt_reg == 3'h1) && !move_start;
      if (move_start)
      begin
        jaw_position <= 16'h03E8;
        cnt_reg <= 3'h4;
      end
      else if (cnt_reg != 3'h0)
        cnt_reg <= cnt_reg - 3'h1;
      if (!move_start && cnt_reg == 3'h1)
        jaw_position <= move_inward ? 16'h07D0 : 16'h0000;
    end
  end
endmodule

// ==== testbench/tb_gpdc_top.sv ====
/*
  Testbench of the gripper command interpreter: handshakes, moves,
  errors and recipes. Assumes design, checker and jaw model built.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) \
  begin error_cnt++; \
  $display("ERROR %0s exp %0h got %0h", n, e, g); end end
module tb_gpdc_top;
  // Profile code, fast in, fast out, hold in, hold out
  localparam [71:0] PT = 72'h3C43F6468499640673;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [15:0] cw = 16'h0000;
  reg [7:0] prf = 8'h64;
  reg [7:0] idx = 8'h00;
  reg [15:0] tpos = 16'h0000;
  reg [7:0] frc = 8'h01;
  reg [7:0] win = 8'h00;
  reg lost = 1'b0;
  reg hf = 1'b0;
  reg [15:0] hfc = 16'h00AB;
  reg ms_seen = 1'b0;
  reg cs_seen = 1'b0;
  reg ab_seen = 1'b0;
  reg [11:0] pe;
  integer error_cnt = 0;
  integer samples_checked = 0;
  integer i;
  wire [15:0] st, diag, jpos;
  wire mdone, mst, inw, fast, cal, hold, abt;
  wire [2:0] mfrc;
  always #5 clk = ~clk;
  gpdc_top #(.HOLD_CYCLES(20)) dut (.clk(clk), .rst_b(rst_b),
    .command_word(cw), .travel_profile_select(prf),
    .recipe_index(idx), .taught_position(tpos), .force_level(frc),
    .position_window(win), .jaw_position(jpos), .motion_done(mdone),
    .workpiece_lost(lost), .hard_fault(hf), .hard_fault_code(hfc),
    .gripper_status(st), .diagnosis(diag), .move_start(mst),
    .move_inward(inw), .move_fast(fast), .move_force(mfrc),
    .move_abort(abt), .calib_start(cal), .hold_current(hold));
  gpdc_jaw_model jaw (.clk(clk), .rst_b(rst_b), .move_start(mst),
    .move_inward(inw), .jaw_position(jpos), .motion_done(mdone));
  // Catch one-cycle pulses
  always @(posedge clk)
  begin
    if (mst)
      ms_seen <= 1'b1;
    if (cal)
      cs_seen <= 1'b1;
    if (abt)
      ab_seen <= 1'b1;
  end
  // ----
  // Access tasks
  // ----
  task put(input [15:0] c);
  begin
    @(negedge clk);
    cw = c;
    ms_seen = 1'b0;
    cs_seen = 1'b0;
  end
  endtask
  task waitst(input integer b, input v);
    integer k;
  begin
    k = 0;
    while (st[b] !== v && k < 60)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 60)
    begin
      error_cnt++;
      $display("ERROR wait st%0d exp %0h got %0h", b, v, st[b]);
      end_of_test;
    end
  end
  endtask
  task xfer(input [7:0] p, input [7:0] n, input [15:0] t,
    input [7:0] f, input [7:0] w);
  begin
    @(negedge clk);
    {prf, idx, tpos, frc, win} = {p, n, t, f, w};
    cw = 16'h0001;
    ab_seen = 1'b0;
    waitst(12, 1'b1);
    `CHK("ack set", 1'b1, st[12])
    `CHK("abort", 1'b1, ab_seen)
    cw = 16'h0000;
    waitst(12, 1'b0);
    `CHK("ack clear", 1'b0, st[12])
  end
  endtask
  task mv(input [15:0] c, input e);
  begin
    put(c);
    repeat (4) @(negedge clk);
    `CHK("move start", e, ms_seen)
  end
  endtask
  task end_of_test;
  begin
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  // Watchdog
  initial
  begin
    #100000;
    error_cnt++;
    end_of_test;
  end
  // ----
  // Tests
  // ----
  initial
  begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    `CHK("boot early", 1'b0, st[6])
    repeat (20) @(negedge clk);
    `CHK("boot, outer", 2'b11, {st[6], st[8]})
    $display("test reset done");
    for (i = 0; i < 6; i++)
    begin
      pe = PT[71-12*i -: 12];
      xfer(pe[11:4], 8'h00, 16'h0000, 8'h02, 8'h00);
      mv(16'h0200, 1'b1);
      `CHK("in req", 5'h15, {inw, mfrc, st[11]})
      `CHK("fast in", pe[3], fast)
      put(16'h0000);
      waitst(10, 1'b1);
      `CHK("dir in", 3'b101, {st[14:13], st[10]})
      repeat (3) @(negedge clk);
      `CHK("hold in", pe[1], hold)
      repeat (30) @(negedge clk);
      `CHK("hold end", 1'b0, hold)
      mv(16'h0100, 1'b1);
      `CHK("fast out", {1'b0, pe[2]}, {inw, fast})
      put(16'h0000);
      waitst(8, 1'b1);
      `CHK("dir out", 3'b011, {st[14:13], st[8]})
      repeat (3) @(negedge clk);
      `CHK("hold out", pe[0], hold)
      repeat (30) @(negedge clk);
    end
    mv(16'h0100, 1'b0);
    put(16'h0004);
    mv(16'h0100, 1'b1);
    put(16'h0000);
    waitst(8, 1'b1);
    $display("test motion done");
    xfer(8'h11, 8'h00, 16'h0000, 8'h02, 8'h00);
    `CHK("bad mode", 17'h10001, {st[15], diag})
    put(16'h8000);
    repeat (3) @(negedge clk);
    `CHK("cleared", 16'h0000, diag)
    put(16'h0000);
    xfer(8'h64, 8'h00, 16'h0000, 8'h05, 8'h00);
    `CHK("bad force", 16'h0002, diag)
    hf = 1'b1;
    put(16'h8000);
    repeat (3) @(negedge clk);
    `CHK("hard kept", 17'h100AB, {st[15], diag})
    hf = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("soft gone", 16'h0000, diag)
    put(16'h0000);
    lost = 1'b1;
    @(negedge clk);
    lost = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("lost", 18'h30003, {ms_seen, fast, diag})
    put(16'h8000);
    put(16'h0000);
    waitst(8, 1'b1);
    $display("test errors done");
    xfer(8'h64, 8'h00, 16'h0005, 8'h02, 8'h05);
    `CHK("in window", 1'b1, st[9])
    xfer(8'h64, 8'h00, 16'h0005, 8'h02, 8'h04);
    `CHK("off window", 1'b0, st[9])
    put(16'h0008);
    repeat (4) @(negedge clk);
    `CHK("teach idx 0", 1'b0, st[9])
    put(16'h0000);
    idx = 8'h03;
    put(16'h0008);
    repeat (4) @(negedge clk);
    `CHK("teach", 1'b1, st[9])
    put(16'h0000);
    xfer(8'h64, 8'h00, 16'h0009, 8'h02, 8'h04);
    `CHK("new spot", 1'b0, st[9])
    xfer(8'h64, 8'h03, 16'h0009, 8'h02, 8'h04);
    `CHK("recipe", 1'b1, st[9])
    $display("test recipes done");
    put(16'h0080);
    repeat (3) @(negedge clk);
    `CHK("calib", 1'b1, cs_seen)
    put(16'h0000);
    put(16'h0180);
    repeat (3) @(negedge clk);
    `CHK("multi", 2'b00, {ms_seen, cs_seen})
    put(16'h0000);
    $display("test commands done");
    end_of_test;
  end
endmodule
